//--- src/glue_map.vh
// Register indices, field positions, reset values and timing counts of the glue register bank.
`ifndef GLUE_MAP_VH
`define GLUE_MAP_VH

`define IDX_PIN60_CFG      8'h47
`define IDX_PIN61_CFG      8'h48
`define IDX_POWER_RECOVERY_CONTROL        8'h49
`define IDX_PON_HISTORY    8'h4a
`define IDX_GP1_RSVD       8'h4b
`define IDX_GP2_DATA       8'h4c
`define IDX_GP3_DATA       8'h4d
`define IDX_GP4_DATA       8'h4e
`define IDX_GP5_DATA       8'h4f
`define IDX_GP6_DATA       8'h50
`define IDX_RSVD_ZERO      8'h51
`define IDX_PREV_SEL       8'h53
`define IDX_PIN62_CFG      8'h54
`define IDX_PIN63_CFG      8'h55
`define IDX_RSVD_56        8'h56
`define IDX_RSVD_59        8'h59
`define IDX_TEST_A         8'h5a
`define IDX_IND1_CTRL      8'h5d
`define IDX_IND2_CTRL      8'h5e
`define IDX_WD_UNIT        8'h65
`define IDX_WD_VALUE       8'h66
`define IDX_WD_CFG         8'h67
`define IDX_WD_CTRL        8'h68
`define IDX_TEST_B         8'h6d
`define IDX_PIN44_CFG      8'h6e
`define IDX_PIN45_CFG      8'h6f
`define IDX_MON_INDEX      8'h70
`define IDX_MON_DATA       8'h71
`define IDX_PIN46_CFG      8'h72
`define IDX_PIN47_CFG      8'h73
`define IDX_EDGE_STATUS    8'h74

`define CFG_DIR_BIT        0
`define CFG_POL_BIT        1
`define CFG_OD_BIT         7
`define CFG_MASK_ALT2      8'h8f
`define CFG_MASK_ALT1      8'h87
`define CFG_MASK_PLAIN     8'h83
`define RST_CFG_6X         8'h01
`define RST_CFG_44         8'h80
`define RST_CFG_4X         8'h00
`define RST_RSVD_56        8'h01

`define GP2_MASK           8'h80
`define GP3_MASK           8'h01
`define GP4_MASK           8'hf4
`define GP5_MASK           8'hff
`define GP6_MASK           8'h0f
`define RST_GP4            8'hf0

`define ALT_SEL_FIRST      2'b11
`define ALT_SEL_EDGE       2'b10
`define ALT_SEL_INDICATOR  2'b01
`define IND_OFF            2'b00
`define IND_BLINK_FAST     2'b01
`define IND_BLINK_SLOW     2'b10
`define IND_ON             2'b11
`define APF_ON             2'b10
`define APF_PREVIOUS       2'b11

`define PCLK_MHZ           125
`define HALF_SECOND_MS     500
`define SECONDS_PER_MINUTE 6'd60

`endif

//--- src/runtime_glue_registers.v
// Runtime glue register bank: pin control, power recovery, indicators, watchdog, monitor window.
//
// Operation
// - Config bits: direction, polarity, open-drain output type.
// - Pin 6.0 selects watchdog, edge, indicator, GPIO.
// - Pin 6.1 selects clock, edge, indicator, GPIO.
// - Either edge sets wake, SYSTEM_MANAGEMENT_INTERRUPT, status bits.
// - Pins 4.4-4.7 default to reset outputs.
// - Power button enabled, recovery disabled by default.
// - Sample request pin each half second.
// - Previous state bit battery-backed, read-only.
// - Policy battery-backed; 00/01 keep supply off.
// - Lock bit makes recovery register read-only.
// - Sample history readable, cleared on battery reset.
// - Select picks previous bit; sample when powered.
// - GP4 and GP6 data registers map one bit per pin.
// - Indicator codes: off, 1 Hz, 0.5 Hz, on.
// - Unit bit selects minutes or seconds.
// - Timeout value zero disables the watchdog.
// - Config upper nibble routes timeout to interrupt.
// - Status bit set on timeout, survives bus reset.
// - Force bit causes timeout and self-clears.
// - Index and data window into monitor.
`timescale 1ns/1ps
`include "glue_map.vh"

module runtime_glue_registers #(
  parameter HALF_SECOND_CYCLES = `HALF_SECOND_MS * 1000 * `PCLK_MHZ
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        battery_resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [7:0]  pin_in,
  output reg  [7:0]  pin_out,
  output reg  [7:0]  pin_oe_n,
  input  wire        power_on_request_pin_n,
  input  wire        main_reset_n,
  input  wire        bus_reset_n,
  input  wire        trickle_ok,
  output reg  [1:0]  wake_event,
  output reg  [1:0]  system_management_interrupt,
  output reg         power_button_enable,
  output reg         power_supply_restore,
  output reg         watchdog_irq_active,
  output reg  [3:0]  watchdog_irq_number,
  output reg  [7:0]  monitor_index,
  output reg  [7:0]  monitor_wdata,
  output reg         monitor_write,
  output reg         monitor_read,
  input  wire [7:0]  monitor_rdata
);

  // Synchronisers for every pin-side input.
  reg  [11:0] sync1_reg;
  reg  [11:0] sync2_reg;
  reg  [1:0]  edge_prev_reg;
  reg         trickle_prev_reg;
  wire [7:0]  pin_sync     = sync2_reg[7:0];
  wire        pon_sync_n   = sync2_reg[8];
  wire        main_on      = sync2_reg[9];
  wire        bus_on       = sync2_reg[10];
  wire        trickle_sync = sync2_reg[11];
  wire        trickle_fall = trickle_prev_reg & ~trickle_sync;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg        <= 12'h000;
      sync2_reg        <= 12'h000;
      edge_prev_reg    <= 2'b00;
      trickle_prev_reg <= 1'b0;
    end else begin
      sync1_reg        <= {trickle_ok, bus_reset_n, main_reset_n, power_on_request_pin_n, pin_in};
      sync2_reg        <= sync1_reg;
      edge_prev_reg    <= sync2_reg[1:0];
      trickle_prev_reg <= sync2_reg[11];
    end
  end

  // APB slave with one wait state; writes commit on the edge that completes the access.
  wire       addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  wire [7:0] idx     = paddr[9:2];
  wire       access  = psel & penable;
  wire       wr_en   = access & pready & pwrite & addr_ok;
  wire [7:0] wd      = pwdata[7:0];
  reg  [7:0] rd_data;
  reg        rd_ok;

  // Pin configuration storage: 6.0, 6.1, 6.2, 6.3, 4.4, 4.5, 4.6, 4.7.
  wire [7:0] cfg_reg [0:7];
  reg  [7:0] gp2_reg;
  reg  [7:0] gp3_reg;
  reg  [7:0] gp4_reg;
  reg  [7:0] gp5_reg;
  reg  [7:0] gp6_reg;
  wire [7:0] pin_data = {gp4_reg[7:4], gp6_reg[3:0]};
  wire [7:0] pin_read;
  wire [7:0] pin_level;
  wire [7:0] pin_drive;

  function [7:0] cfg_index;
    input integer n;
    begin
      case (n)
        0:       cfg_index = `IDX_PIN60_CFG;
        1:       cfg_index = `IDX_PIN61_CFG;
        2:       cfg_index = `IDX_PIN62_CFG;
        3:       cfg_index = `IDX_PIN63_CFG;
        4:       cfg_index = `IDX_PIN44_CFG;
        5:       cfg_index = `IDX_PIN45_CFG;
        6:       cfg_index = `IDX_PIN46_CFG;
        default: cfg_index = `IDX_PIN47_CFG;
      endcase
    end
  endfunction

  function [7:0] cfg_reset;
    input integer n;
    begin
      if (n < 4)
        cfg_reset = `RST_CFG_6X;
      else if (n == 4)
        cfg_reset = `RST_CFG_44;
      else
        cfg_reset = `RST_CFG_4X;
    end
  endfunction

  function [7:0] cfg_mask;
    input integer n;
    begin
      if (n < 2)
        cfg_mask = `CFG_MASK_ALT2;
      else if (n < 4)
        cfg_mask = `CFG_MASK_PLAIN;
      else
        cfg_mask = `CFG_MASK_ALT1;
    end
  endfunction

  // Power recovery, indicators, edge status and test storage.
  reg        btn_en_reg;
  reg        rec_bit1_reg;
  reg        lock_reg;
  reg        rec_en_reg;
  reg        samp_en_reg;
  reg        prev_bit_reg;
  reg  [1:0] apf_reg;
  reg  [7:0] history_reg;
  reg  [3:0] prev_sel_reg;
  reg  [7:0] test_b_reg;
  reg  [1:0] ind1_reg;
  reg  [1:0] ind2_reg;
  reg  [1:0] edge_sts_reg;
  reg        started_reg;

  // Watchdog state.
  reg        wd_unit_reg;
  reg  [7:0] wd_value_reg;
  reg  [3:0] wd_cfg_reg;
  reg  [7:0] wd_count_reg;
  reg        wd_status_reg;
  reg        wd_force_reg;

  // Half-second time base, second and minute ticks, blink phase.
  reg  [31:0] half_cnt_reg;
  reg         sec_half_reg;
  reg  [5:0]  min_cnt_reg;
  reg  [1:0]  phase_reg;
  wire        half_tick = (half_cnt_reg == HALF_SECOND_CYCLES - 1);
  wire        sec_tick  = half_tick & sec_half_reg;
  wire        min_tick  = sec_tick & (min_cnt_reg == `SECONDS_PER_MINUTE - 6'd1);
  wire        unit_tick = wd_unit_reg ? sec_tick : min_tick;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_reg <= 32'h0;
      sec_half_reg <= 1'b0;
      min_cnt_reg  <= 6'h00;
      phase_reg    <= 2'b00;
    end else begin
      half_cnt_reg <= half_tick ? 32'h0 : half_cnt_reg + 32'h1;
      if (half_tick) begin
        sec_half_reg <= ~sec_half_reg;
        phase_reg    <= phase_reg + 2'b01;
      end
      if (sec_tick)
        min_cnt_reg <= min_tick ? 6'h00 : min_cnt_reg + 6'h01;
    end
  end

  function ind_level;
    input [1:0] mode;
    input [1:0] phase;
    begin
      case (mode)
        `IND_BLINK_FAST: ind_level = ~phase[0];
        `IND_BLINK_SLOW: ind_level = (phase == 2'b00);
        `IND_ON:         ind_level = 1'b1;
        default:         ind_level = 1'b0;
      endcase
    end
  endfunction

  wire ind1_on = ind_level(ind1_reg, phase_reg);
  wire ind2_on = ind_level(ind2_reg, phase_reg);
  wire clk_out = phase_reg[0];

  // Per-pin configuration registers and pad drive.
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : pin
      reg  [7:0] cfg_q;
      wire [7:0] c      = cfg_q;
      wire       is_in  = c[`CFG_DIR_BIT];
      wire       inv    = c[`CFG_POL_BIT];
      wire       od     = c[`CFG_OD_BIT];
      reg        func;
      reg        edge_mode;
      always @* begin
        func      = pin_data[g];
        edge_mode = 1'b0;
        if (g == 0) begin
          case (c[3:2])
            `ALT_SEL_FIRST:     func = wd_status_reg;
            `ALT_SEL_EDGE:      edge_mode = 1'b1;
            `ALT_SEL_INDICATOR: func = ind1_on;
            default:            func = pin_data[g];
          endcase
        end else if (g == 1) begin
          case (c[3:2])
            `ALT_SEL_FIRST:     func = clk_out;
            `ALT_SEL_EDGE:      edge_mode = 1'b1;
            `ALT_SEL_INDICATOR: func = ind2_on;
            default:            func = pin_data[g];
          endcase
        end else if (g >= 4) begin
          func = c[2] ? pin_data[g] : bus_on;
        end
      end
      assign cfg_reg[g]   = cfg_q;
      assign pin_level[g] = func ^ inv;
      assign pin_drive[g] = ~is_in & ~edge_mode & ~(od & pin_level[g]);
      assign pin_read[g] = is_in ? (pin_sync[g] ^ inv) : pin_data[g];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          cfg_q <= cfg_reset(g);
        else if (wr_en && idx == cfg_index(g))
          cfg_q <= wd & cfg_mask(g);
      end
    end
  endgenerate

  // One process drives the pads so that each output has a single driver.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out  <= 8'h00;
      pin_oe_n <= 8'hff;
    end else begin
      pin_out  <= pin_level;
      pin_oe_n <= ~pin_drive;
    end
  end

  // Either-edge inputs on pins 6.0 and 6.1.
  wire [1:0] edge_evt;
  assign edge_evt[0] = (cfg_reg[0][3:2] == `ALT_SEL_EDGE) & (edge_prev_reg[0] ^ pin_sync[0]);
  assign edge_evt[1] = (cfg_reg[1][3:2] == `ALT_SEL_EDGE) & (edge_prev_reg[1] ^ pin_sync[1]);
  wire       edge_clr = wr_en && idx == `IDX_EDGE_STATUS;

  // Trickle-supply registers: data, indicators, window, lock and edge status.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp2_reg                     <= 8'h00;
      gp3_reg                     <= 8'h00;
      gp4_reg                     <= `RST_GP4;
      gp5_reg                     <= 8'h00;
      gp6_reg                     <= 8'h00;
      ind1_reg                    <= `IND_OFF;
      ind2_reg                    <= `IND_OFF;
      monitor_index               <= 8'h00;
      monitor_wdata               <= 8'h00;
      monitor_write               <= 1'b0;
      monitor_read                <= 1'b0;
      btn_en_reg                  <= 1'b1;
      rec_bit1_reg                <= 1'b1;
      lock_reg                    <= 1'b0;
      edge_sts_reg                <= 2'b00;
      wake_event                  <= 2'b00;
      system_management_interrupt <= 2'b00;
      power_button_enable         <= 1'b1;
    end else begin
      if (wr_en) begin
        case (idx)
          `IDX_GP2_DATA:  gp2_reg <= wd & `GP2_MASK;
          `IDX_GP3_DATA:  gp3_reg <= wd & `GP3_MASK;
          `IDX_GP4_DATA:  gp4_reg <= wd & `GP4_MASK;
          `IDX_GP5_DATA:  gp5_reg <= wd & `GP5_MASK;
          `IDX_GP6_DATA:  gp6_reg <= wd & `GP6_MASK;
          `IDX_IND1_CTRL: ind1_reg <= wd[1:0];
          `IDX_IND2_CTRL: ind2_reg <= wd[1:0];
          `IDX_MON_INDEX: monitor_index <= wd;
          `IDX_MON_DATA:  monitor_wdata <= wd;
          default:        ;
        endcase
      end
      monitor_write <= wr_en && idx == `IDX_MON_DATA;
      monitor_read  <= access & ~pready & ~pwrite & addr_ok & (idx == `IDX_MON_DATA);
      if (!main_on || !bus_on) begin
        lock_reg <= 1'b0;
      end else if (wr_en && idx == `IDX_POWER_RECOVERY_CONTROL && !lock_reg) begin
        btn_en_reg   <= wd[0];
        rec_bit1_reg <= wd[1];
        lock_reg     <= wd[7];
      end
      edge_sts_reg[0] <= edge_evt[0] | (edge_sts_reg[0] & ~(edge_clr & wd[0]));
      edge_sts_reg[1] <= edge_evt[1] | (edge_sts_reg[1] & ~(edge_clr & wd[1]));
      wake_event                  <= edge_evt;
      system_management_interrupt <= edge_evt;
      power_button_enable         <= btn_en_reg;
    end
  end

  // Battery-backed registers survive the trickle-supply reset.
  always @(posedge pclk or negedge battery_resetn) begin
    if (!battery_resetn) begin
      rec_en_reg   <= 1'b0;
      samp_en_reg  <= 1'b0;
      apf_reg      <= 2'b00;
      prev_bit_reg <= 1'b0;
      history_reg  <= 8'h00;
      prev_sel_reg <= 4'h0;
      test_b_reg   <= 8'h00;
    end else begin
      if (wr_en && idx == `IDX_POWER_RECOVERY_CONTROL && !lock_reg) begin
        rec_en_reg  <= wd[2];
        samp_en_reg <= wd[3];
        apf_reg     <= wd[6:5];
      end
      if (wr_en && idx == `IDX_PREV_SEL)
        prev_sel_reg <= wd[3:0];
      if (wr_en && idx == `IDX_TEST_B)
        test_b_reg <= wd;
      if (samp_en_reg && main_on && trickle_sync && half_tick)
        history_reg <= {history_reg[6:0], ~pon_sync_n};
      if (trickle_fall)
        prev_bit_reg <= history_reg[prev_sel_reg[2:0]];
    end
  end

  // Supply policy evaluated once when trickle power returns.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started_reg          <= 1'b0;
      power_supply_restore <= 1'b0;
    end else begin
      started_reg <= 1'b1;
      if (!started_reg)
        power_supply_restore <= rec_en_reg & ((apf_reg == `APF_ON) |
                                ((apf_reg == `APF_PREVIOUS) & prev_bit_reg));
      else if (main_on)
        power_supply_restore <= 1'b0;
    end
  end

  // Watchdog.
  wire wd_ctrl_wr = wr_en && idx == `IDX_WD_CTRL;
  wire wd_expire  = unit_tick & (wd_value_reg != 8'h00) & (wd_count_reg == 8'h01);
  wire wd_timeout = wd_expire | wd_force_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_unit_reg         <= 1'b0;
      wd_value_reg        <= 8'h00;
      wd_cfg_reg          <= 4'h0;
      wd_count_reg        <= 8'h00;
      wd_status_reg       <= 1'b0;
      wd_force_reg        <= 1'b0;
      watchdog_irq_active <= 1'b0;
      watchdog_irq_number <= 4'h0;
    end else if (!main_on || !bus_on) begin
      wd_unit_reg  <= 1'b0;
      wd_value_reg <= 8'h00;
      wd_cfg_reg   <= 4'h0;
      wd_count_reg <= 8'h00;
      wd_force_reg <= 1'b0;
      if (!main_on)
        wd_status_reg <= 1'b0;
      watchdog_irq_active <= 1'b0;
      watchdog_irq_number <= 4'h0;
    end else begin
      if (wr_en && idx == `IDX_WD_UNIT)
        wd_unit_reg <= wd[7];
      if (wr_en && idx == `IDX_WD_CFG)
        wd_cfg_reg <= wd[7:4];
      wd_force_reg <= wd_ctrl_wr & wd[2];
      if (wr_en && idx == `IDX_WD_VALUE) begin
        wd_value_reg <= wd;
        wd_count_reg <= wd;
      end else if (wd_ctrl_wr && !wd[0]) begin
        wd_count_reg <= wd_value_reg;
      end else if (unit_tick && wd_count_reg != 8'h00 && !wd_status_reg) begin
        wd_count_reg <= wd_count_reg - 8'h01;
      end
      if (wd_timeout)
        wd_status_reg <= 1'b1;
      else if (wd_ctrl_wr)
        wd_status_reg <= wd[0];
      watchdog_irq_active <= wd_status_reg & (wd_cfg_reg != 4'h0);
      watchdog_irq_number <= wd_cfg_reg;
    end
  end

  // Read multiplexer.
  always @* begin
    rd_data = 8'h00;
    rd_ok   = addr_ok;
    case (idx)
      `IDX_PIN60_CFG:   rd_data = cfg_reg[0];
      `IDX_PIN61_CFG:   rd_data = cfg_reg[1];
      `IDX_PIN62_CFG:   rd_data = cfg_reg[2];
      `IDX_PIN63_CFG:   rd_data = cfg_reg[3];
      `IDX_PIN44_CFG:   rd_data = cfg_reg[4];
      `IDX_PIN45_CFG:   rd_data = cfg_reg[5];
      `IDX_PIN46_CFG:   rd_data = cfg_reg[6];
      `IDX_PIN47_CFG:   rd_data = cfg_reg[7];
      `IDX_POWER_RECOVERY_CONTROL:     rd_data = {lock_reg, apf_reg, prev_bit_reg, samp_en_reg, rec_en_reg,
                                   rec_bit1_reg, btn_en_reg};
      `IDX_PON_HISTORY: rd_data = history_reg;
      `IDX_GP1_RSVD:    rd_data = 8'h00;
      `IDX_GP2_DATA:    rd_data = gp2_reg;
      `IDX_GP3_DATA:    rd_data = gp3_reg;
      `IDX_GP4_DATA:    rd_data = {pin_read[7:4], 1'b0, gp4_reg[2], 2'b00};
      `IDX_GP5_DATA:    rd_data = gp5_reg;
      `IDX_GP6_DATA:    rd_data = {4'h0, pin_read[3:0]};
      `IDX_RSVD_ZERO:   rd_data = 8'h00;
      `IDX_PREV_SEL:    rd_data = {4'h0, prev_sel_reg};
      `IDX_TEST_A:      rd_data = 8'h00;
      `IDX_IND1_CTRL:   rd_data = {6'h00, ind1_reg};
      `IDX_IND2_CTRL:   rd_data = {6'h00, ind2_reg};
      `IDX_WD_UNIT:     rd_data = {wd_unit_reg, 7'h00};
      `IDX_WD_VALUE:    rd_data = wd_value_reg;
      `IDX_WD_CFG:      rd_data = {wd_cfg_reg, 4'h0};
      `IDX_WD_CTRL:     rd_data = {7'h00, wd_status_reg};
      `IDX_TEST_B:      rd_data = test_b_reg;
      `IDX_MON_INDEX:   rd_data = monitor_index;
      `IDX_MON_DATA:    rd_data = monitor_rdata;
      `IDX_EDGE_STATUS: rd_data = {6'h00, edge_sts_reg};
      default: begin
        if (idx >= `IDX_RSVD_56 && idx <= `IDX_RSVD_59)
          rd_data = `RST_RSVD_56;
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (access && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~rd_ok;
      prdata  <= (pwrite || !rd_ok) ? 32'h0 : {24'h0, rd_data};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

//--- test/glue_checker_assertions.sv
// Concurrent checks on the ports of the runtime glue register bank.
`timescale 1ns/1ps
module glue_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [1:0]  wake_event,
  input wire [1:0]  system_management_interrupt,
  input wire        watchdog_irq_active,
  input wire [3:0]  watchdog_irq_number,
  input wire        monitor_write,
  input wire        monitor_read,
  input wire [7:0]  monitor_wdata
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");
  wait_state_a: assert property ($rose(penable) && psel |=> pready)
    else $error("ready not one cycle after access start");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  upper_zero_a: assert property (prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  edge_pair_a: assert property (wake_event == system_management_interrupt)
    else $error("wake and management pulses differ");
  irq_route_a: assert property (watchdog_irq_active |-> watchdog_irq_number != 4'h0)
    else $error("interrupt active with routing disabled");
  mon_write_a: assert property (psel && penable && pready && pwrite && paddr == 12'h1c4
    |=> monitor_write && monitor_wdata == $past(pwdata[7:0]))
    else $error("monitor write not forwarded");
  mon_read_a: assert property (psel && penable && !pready && !pwrite && paddr == 12'h1c4
    |=> monitor_read)
    else $error("monitor read not forwarded");
  unmapped_a: assert property (psel && penable && pready && paddr == 12'h148 |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind runtime_glue_registers glue_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .wake_event, .system_management_interrupt,
  .watchdog_irq_active, .watchdog_irq_number, .monitor_write, .monitor_read, .monitor_wdata);

//--- test/tb_top.sv
// Self-checking bench for the runtime glue register bank.
`timescale 1ns/1ps
module tb_top;
  reg          pclk, presetn, battery_resetn, psel, penable, pwrite, e;
  reg  [11:0]  paddr;
  reg  [31:0]  pwdata, seed;
  reg  [7:0]   pin_in, monitor_rdata, r;
  reg  [7:0]   model [0:255];
  reg          power_on_request_pin_n, main_reset_n, bus_reset_n, trickle_ok;
  reg  [191:0] lst;
  wire [31:0]  prdata;
  wire         pready, pslverr, power_button_enable, power_supply_restore;
  wire         watchdog_irq_active, monitor_write, monitor_read;
  wire [7:0]   pin_out, pin_oe_n, monitor_index, monitor_wdata;
  wire [1:0]   wake_event, system_management_interrupt;
  wire [3:0]   watchdog_irq_number;
  integer      errors, total_checks, cyc, n, i;
  runtime_glue_registers #(.HALF_SECOND_CYCLES(4)) DUT (.pclk, .presetn, .battery_resetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in,
    .pin_out, .pin_oe_n, .power_on_request_pin_n, .main_reset_n, .bus_reset_n,
    .trickle_ok, .wake_event, .system_management_interrupt, .power_button_enable,
    .power_supply_restore, .watchdog_irq_active, .watchdog_irq_number, .monitor_index,
    .monitor_wdata, .monitor_write, .monitor_read, .monitor_rdata);
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task stop_test;
    begin
      $display("errors=%0d total_checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] x);
    begin
      total_checks = total_checks + 1;
      if (s !== x) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, s, x);
      end
    end
  endtask
  task cy(input integer k);
    repeat (k) @(posedge pclk);
  endtask
  task apb(input [7:0] a, input w, input [7:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, a, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d, input [7:0] k);
    begin
      apb(a, 1'b1, d);
      model[a] = d & k;
    end
  endtask
  task rd(input [7:0] a);
    begin
      apb(a, 1'b0, 8'h00);
      chk(r, model[a]);
    end
  endtask
  task edge_in(input v);
    begin
      @(posedge pclk);
      pin_in[0] <= v;
      n = 0;
      @(negedge pclk);
      while (wake_event[0] !== 1'b1 && n < 12) begin
        @(negedge pclk);
        n = n + 1;
      end
      chk(n < 12, 1);
    end
  endtask
  task pulse(input b);
    begin
      @(posedge pclk);
      if (b)
        bus_reset_n <= 1'b0;
      else
        main_reset_n <= 1'b0;
      cy(5);
      chk(pin_oe_n[4], !b);
      chk(pin_out[4], !b);
      bus_reset_n <= 1'b1;
      main_reset_n <= 1'b1;
      cy(6);
      model[8'h65] = 8'h00;
      model[8'h66] = 8'h00;
      model[8'h67] = 8'h00;
    end
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      stop_test;
    end
  end
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    {presetn, battery_resetn, psel, penable, pwrite} = 5'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pin_in = 8'hff;
    monitor_rdata = 8'h00;
    {power_on_request_pin_n, main_reset_n, bus_reset_n, trickle_ok} = 4'hf;
    {errors, total_checks, cyc} = 0;
    seed = 32'd74971;
    for (i = 0; i < 256; i = i + 1)
      model[i] = 8'h00;
    {model[8'h47], model[8'h48], model[8'h54], model[8'h55], model[8'h56]} = {5{8'h01}};
    model[8'h6e] = 8'h80;
    model[8'h4e] = 8'hf0;
    model[8'h49] = 8'h03;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    battery_resetn <= 1'b1;
    cy(6);
    lst = 192'h4748494a4c4d4e4f5154555d6566676e686f7072735a5e53;
    for (i = 0; i < 24; i = i + 1)
      rd(lst[191-8*i -: 8]);
    chk(power_supply_restore, 1'b0);
    lst = 192'h4c804d014fff6580530f6f87;
    for (i = 0; i < 36; i = i + 1) begin
      seed = xs(seed);
      wr(lst[95-16*(i%6) -: 8], seed[7:0] & ((i%6 == 3) ? 8'hfc : 8'hff), lst[87-16*(i%6) -: 8]);
      rd(lst[95-16*(i%6) -: 8]);
    end
    apb(8'h52, 1'b0, 8'h00);
    chk({e, r}, 9'h100);
    apb(8'h56, 1'b1, 8'hff);
    rd(8'h56);
    apb(8'h4a, 1'b1, 8'hff);
    rd(8'h4a);
    seed = xs(seed);
    wr(8'h70, seed[7:0], 8'hff);
    cy(1);
    chk(monitor_index, model[8'h70]);
    wr(8'h71, seed[15:8], 8'hff);
    cy(1);
    chk(monitor_wdata, seed[15:8]);
    monitor_rdata <= seed[23:16];
    apb(8'h71, 1'b0, 8'h00);
    chk(r, seed[23:16]);
    wr(8'h49, 8'h1e, 8'h0e);
    rd(8'h49);
    chk(power_button_enable, 1'b0);
    wr(8'h49, 8'h8f, 8'hff);
    apb(8'h49, 1'b1, 8'h02);
    rd(8'h49);
    chk(power_button_enable, 1'b1);
    power_on_request_pin_n <= 1'b0;
    cy(48);
    model[8'h4a] = 8'hff;
    rd(8'h4a);
    trickle_ok <= 1'b0;
    cy(6);
    trickle_ok <= 1'b1;
    model[8'h49] = 8'h9f;
    rd(8'h49);
    power_on_request_pin_n <= 1'b1;
    cy(48);
    model[8'h4a] = 8'h00;
    rd(8'h4a);
    wr(8'h48, 8'h04, 8'h8f);
    wr(8'h5e, 8'h03, 8'h03);
    cy(4);
    chk({pin_out[1], pin_oe_n[1]}, 2'b10);
    wr(8'h5e, 8'h00, 8'h03);
    cy(4);
    chk({pin_out[1], pin_oe_n[1]}, 2'b00);
    wr(8'h48, 8'h86, 8'h8f);
    cy(4);
    chk({pin_out[1], pin_oe_n[1]}, 2'b11);
    wr(8'h47, 8'h09, 8'h8f);
    cy(6);
    edge_in(1'b0);
    edge_in(1'b1);
    model[8'h74] = 8'h01;
    rd(8'h74);
    wr(8'h74, 8'h01, 8'h00);
    rd(8'h74);
    wr(8'h65, 8'h80, 8'h80);
    wr(8'h67, 8'h50, 8'hf0);
    wr(8'h66, 8'h02, 8'hff);
    n = 0;
    while (watchdog_irq_active !== 1'b1 && n < 60) begin
      @(negedge pclk);
      n = n + 1;
    end
    chk(n >= 8 && n < 40, 1);
    chk(watchdog_irq_number, 4'h5);
    model[8'h68] = 8'h01;
    rd(8'h68);
    wr(8'h66, 8'h00, 8'hff);
    wr(8'h68, 8'h00, 8'hff);
    rd(8'h68);
    cy(40);
    chk(watchdog_irq_active, 1'b0);
    wr(8'h68, 8'h04, 8'h01);
    cy(3);
    model[8'h68] = 8'h01;
    rd(8'h68);
    pulse(1'b1);
    rd(8'h68);
    rd(8'h67);
    pulse(1'b0);
    model[8'h68] = 8'h00;
    model[8'h49] = 8'h1f;
    rd(8'h68);
    rd(8'h49);
    stop_test;
  end
endmodule
